/* hw/pcisp_pkg.sv */
package pcisp_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_EXTDATA = 8'h0a;
   localparam logic [7:0] IDX_GPCMD = 8'h0b;
   localparam logic [7:0] IDX_STATUS = 8'h0c;
   localparam logic [7:0] IDX_MISC2 = 8'h1e;

   // Second miscellaneous control register fields
   localparam int MISC2_ALTCLK = 0;
   localparam int MISC2_GPMODE = 1;
   localparam int MISC2_PCIINT = 2;
   localparam int MISC2_HALVE = 4;
   localparam int MISC2_RING = 7;

   // Status register fields
   localparam int ST_APERR = 0;
   localparam int ST_DPERR = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_SENSE1 = 3;
   localparam int ST_SENSE2 = 4;

   // Values after reset
   localparam logic [7:0] MISC2_RST = 8'h00;
   localparam logic [7:0] EXTDATA_RST = 8'h00;

   // Strobe timing, rounded up to whole cycles
   localparam int CLK_PERIOD_NS = 10;
   localparam int STB_NS = 40;
   localparam logic [3:0] STB_CYC = 4'((STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {GP_IDLE, GP_SETUP, GP_STROBE, GP_HOLD} pcisp_gp_e;

   // Byte address of a register index
   function automatic logic [11:0] reg_addr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

   // Parity bit that makes the ones over data and command even
   function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
      return ^{ad, cbe};
   endfunction

endpackage

/* hw/pcisp_gp_if.sv */
interface pcisp_gp_if;
   logic start_out;
   logic start_in;
   logic [7:0] wdata;
   logic [3:0] nib_in;
   logic busy;
   logic in_done;
   logic [7:0] rdata;
   logic [3:0] nib_o;
   logic nib_oe;
   logic [1:0] stb_n;

   modport ctrl (output start_out, start_in, wdata, nib_in,
                 input busy, in_done, rdata, nib_o, nib_oe, stb_n);
   modport eng (input start_out, start_in, wdata, nib_in,
                output busy, in_done, rdata, nib_o, nib_oe, stb_n);
endinterface

/* hw/pcisp_sync.sv */
module pcisp_sync #(parameter int W = 1)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pcisp_sync_s;

   pcisp_sync_s q;
   pcisp_sync_s d;

   // Two stages; only the second stage is read outside
   always_comb
   begin
      d.s1 = din;
      d.s2 = q.s1;
   end

   // Pure flops on the rising edge, so a stopped clock just freezes state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule

/* hw/pcisp_gpbus.sv */
module pcisp_gpbus
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Engine side of the nibble bus
   pcisp_gp_if.eng gp
);
   typedef struct packed {
      pcisp_pkg::pcisp_gp_e st;
      logic [3:0] cnt;
      logic nib;
      logic dir_in;
      logic [7:0] data;
      logic [3:0] nib_o;
      logic nib_oe;
      logic [1:0] stb_n;
      logic in_done;
   } pcisp_gp_s;

   pcisp_gp_s q;
   pcisp_gp_s d;

   // Two nibbles, low first, each under its own strobe
   always_comb
   begin
      d = q;
      d.in_done = 1'b0;
      case (q.st)
         pcisp_pkg::GP_IDLE:
         begin
            d.nib_oe = 1'b0;
            if (gp.start_out || gp.start_in)
            begin
               d.st = pcisp_pkg::GP_SETUP;
               d.nib = 1'b0;
               d.dir_in = gp.start_in;
               d.data = gp.wdata;
            end
         end
         pcisp_pkg::GP_SETUP:
         begin
            // Data is set on the same edge as the strobe falls
            d.nib_oe = !q.dir_in;
            d.nib_o = q.nib ? q.data[7:4] : q.data[3:0];
            d.st = pcisp_pkg::GP_STROBE;
            d.cnt = pcisp_pkg::STB_CYC - 4'h1;
            d.stb_n[q.nib] = 1'b0;
         end
         pcisp_pkg::GP_STROBE:
         begin
            if (q.cnt == 4'h0)
            begin
               d.st = pcisp_pkg::GP_HOLD;
               d.stb_n = 2'h3;
               if (q.dir_in)
               begin
                  if (q.nib)
                     d.data[7:4] = gp.nib_in;
                  else
                     d.data[3:0] = gp.nib_in;
               end
            end
            else
            begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         default:
         begin
            // Hold cycle keeps data on the pins past the rising strobe
            if (q.nib)
            begin
               d.st = pcisp_pkg::GP_IDLE;
               d.in_done = q.dir_in;
            end
            else
            begin
               d.st = pcisp_pkg::GP_SETUP;
               d.nib = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '{st: pcisp_pkg::GP_IDLE, stb_n: 2'h3, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   assign gp.busy = (q.st != pcisp_pkg::GP_IDLE);
   assign gp.in_done = q.in_done;
   assign gp.rdata = q.data;
   assign gp.nib_o = q.nib_o;
   assign gp.nib_oe = q.nib_oe;
   assign gp.stb_n = q.stb_n;

   // Checks
   sequence s_first_strobe;
      $fell(q.stb_n[0]);
   endsequence

   sequence s_second_strobe;
      $fell(q.stb_n[1]);
   endsequence

   a_two_nibble_order: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st == pcisp_pkg::GP_IDLE && gp.start_out) |-> ##2 s_first_strobe ##6 s_second_strobe)
      else $error("Nibble strobes out of order");

   a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(q.stb_n[0]) |-> (!q.stb_n[0])[*4] ##1 q.stb_n[0])
      else $error("Strobe width wrong");

   a_data_stable: assert property (@(posedge pclk) disable iff (!presetn)
      (q.stb_n != 2'h3) |=> $stable(q.nib_o))
      else $error("Nibble changed around strobe");
endmodule

/* hw/pcisp_pins.sv */
// Behaviour
// - Parity is checked one clock after every address phase and every completed write data phase.
// - On reads parity is driven from the cycle after target ready until one after the phase ends.
// - The parity bit makes the ones across the 32 data lines and 4 command lines even.
// - All bus inputs except reset and interrupt lines are sampled on the rising clock edge.
// - The logic works at any bus clock rate up to 33 MHz, including a stopped clock.
// - The top interrupt pin carries ring indicate instead of a request when its select bit is set.
// - With its select bit set the second pin becomes an input clock for card timing while idle.
// - Interrupt pins carry requests; the four low pins run legacy active high or shared low.
// - The four middle pins form a nibble bus with two strobes moving the eight bit data register.
//
// Chosen here: register access over APB.
module pcisp_pins
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Bus pins sampled for parity
   input wire logic [31:0] ad_i,
   input wire logic [3:0] cbe_n_i,
   input wire logic frame_n_i,
   input wire logic irdy_n_i,
   input wire logic par_i,
   output logic par_o,
   output logic par_oe,
   // Own target logic, same clock
   input wire logic tgt_read,
   input wire logic tgt_trdy,
   input wire logic [31:0] tgt_rdata,
   // Interrupt requests from card events, same clock
   input wire logic top_req,
   input wire logic second_req,
   input wire logic [3:0] mid_req,
   input wire logic [3:0] low_req,
   input wire logic ring_in,
   // Interrupt pins
   output logic top_irq_or_ring_out_o,
   output logic top_irq_or_ring_out_oe,
   input wire logic second_irq_or_alt_clock_i,
   output logic second_irq_or_alt_clock_o,
   output logic second_irq_or_alt_clock_oe,
   input wire logic [3:0] mid_irq_i,
   output logic [3:0] mid_irq_o,
   output logic [3:0] mid_irq_oe,
   output logic [3:0] legacy_irq_or_pci_line_o,
   output logic [3:0] legacy_irq_or_pci_line_oe,
   // Sense and strobe pins
   input wire logic sense_or_strobe_one_i,
   output logic sense_or_strobe_one_o,
   output logic sense_or_strobe_one_oe,
   input wire logic sense_or_strobe_two_i,
   output logic sense_or_strobe_two_o,
   output logic sense_or_strobe_two_oe,
   // Card timing tick
   output logic timer_tick
);
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] misc2;
      logic [7:0] extdata;
      logic aperr;
      logic dperr;
      logic a_chk;
      logic d_chk;
      logic exp_par;
      logic wr_cyc;
      logic frame_prev;
      logic [1:0] trdy_dly;
      logic par_o;
      logic par_oe;
      logic top_o;
      logic top_oe;
      logic sec_o;
      logic sec_oe;
      logic [3:0] mid_o;
      logic [3:0] mid_oe;
      logic [3:0] low_o;
      logic [3:0] low_oe;
      logic [1:0] stb_o;
      logic stb_oe;
      logic alt_prev;
      logic div;
      logic tick;
      logic start_out;
      logic start_in;
   } pcisp_top_s;

   pcisp_top_s q;
   pcisp_top_s d;

   logic [31:0] ad_s;
   logic [3:0] cbe_s;
   logic frame_s;
   logic irdy_s;
   logic par_s;
   logic ring_s;
   logic alt_s;
   logic [3:0] mid_s;
   logic sense1_s;
   logic sense2_s;
   logic sel_misc2;
   logic sel_ext;
   logic sel_cmd;
   logic sel_stat;
   logic wr_acc;
   logic [31:0] rd_word;
   logic addr_ph;
   logic src;

   pcisp_gp_if gp ();

   ////////////////////////////////////////////////////////////////////////////
   // Every pin input passes two flops first
   pcisp_sync #(.W(47)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .din({ad_i, cbe_n_i, frame_n_i, irdy_n_i, par_i, ring_in,
            second_irq_or_alt_clock_i, mid_irq_i, sense_or_strobe_one_i,
            sense_or_strobe_two_i}),
      .dout({ad_s, cbe_s, frame_s, irdy_s, par_s, ring_s, alt_s, mid_s,
             sense1_s, sense2_s})
   );

   // Nibble bus engine
   pcisp_gpbus u_gpbus
   (
      .pclk(pclk),
      .presetn(presetn),
      .gp(gp.eng)
   );

   assign gp.start_out = q.start_out;
   assign gp.start_in = q.start_in;
   assign gp.wdata = q.extdata;
   assign gp.nib_in = mid_s;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and read mux
   always_comb
   begin
      sel_misc2 = 1'b0;
      sel_ext = 1'b0;
      sel_cmd = 1'b0;
      sel_stat = 1'b0;
      if (paddr == pcisp_pkg::reg_addr(pcisp_pkg::IDX_MISC2))
         sel_misc2 = 1'b1;
      else if (paddr == pcisp_pkg::reg_addr(pcisp_pkg::IDX_EXTDATA))
         sel_ext = 1'b1;
      else if (paddr == pcisp_pkg::reg_addr(pcisp_pkg::IDX_GPCMD))
         sel_cmd = 1'b1;
      else if (paddr == pcisp_pkg::reg_addr(pcisp_pkg::IDX_STATUS))
         sel_stat = 1'b1;
   end

   assign rd_word = sel_misc2 ? {24'h0, q.misc2} :
                    sel_ext ? {24'h0, q.extdata} :
                    sel_stat ? {27'h0, sense2_s, sense1_s, gp.busy, q.dperr, q.aperr} :
                    32'h0;

   // Write commits only at the edge that completes the access
   assign wr_acc = psel && penable && q.pready && pwrite && !q.pslverr;

   // Address phase is the first cycle with frame low
   assign addr_ph = !frame_s && q.frame_prev;

   // Timing source: in clock mode, rising pin edges while the bus idles, else every clock
   assign src = (q.misc2[pcisp_pkg::MISC2_ALTCLK] && frame_s) ?
                (alt_s && !q.alt_prev) : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      d = q;
      d.start_out = 1'b0;
      d.start_in = 1'b0;

      // One wait state gives time to register read data
      if (psel && penable && !q.pready)
      begin
         d.pready = 1'b1;
         d.pslverr = !(sel_misc2 || sel_ext || sel_cmd || sel_stat);
         d.prdata = rd_word;
      end
      else
      begin
         d.pready = 1'b0;
         d.pslverr = 1'b0;
      end

      // Register writes; data writes while the nibble bus is busy are dropped
      if (wr_acc && sel_misc2)
      begin
         d.misc2 = pwdata[7:0];
      end
      else if (wr_acc && sel_ext && !gp.busy)
      begin
         d.extdata = pwdata[7:0];
         d.start_out = q.misc2[pcisp_pkg::MISC2_GPMODE];
      end
      else if (wr_acc && sel_cmd && !gp.busy)
      begin
         d.start_in = pwdata[0] && q.misc2[pcisp_pkg::MISC2_GPMODE];
      end
      if (gp.in_done)
         d.extdata = gp.rdata;

      // Parity check pipeline aligned with the synchronised pins
      d.frame_prev = frame_s;
      d.trdy_dly = {q.trdy_dly[0], tgt_trdy};
      d.a_chk = addr_ph;
      if (addr_ph)
         d.wr_cyc = cbe_s[0];
      d.d_chk = q.wr_cyc && !irdy_s && q.trdy_dly[1] && !addr_ph;
      d.exp_par = pcisp_pkg::even_par(ad_s, cbe_s);

      // Status flags: a new error wins over a clear in the same cycle
      d.aperr = (q.aperr && !(wr_acc && sel_stat && pwdata[pcisp_pkg::ST_APERR]))
                || (q.a_chk && (par_s != q.exp_par));
      d.dperr = (q.dperr && !(wr_acc && sel_stat && pwdata[pcisp_pkg::ST_DPERR]))
                || (q.d_chk && (par_s != q.exp_par));

      // Read parity follows target ready by one cycle
      d.par_oe = tgt_read && tgt_trdy;
      d.par_o = pcisp_pkg::even_par(tgt_rdata, cbe_s);

      // Card timing tick with optional halving
      d.alt_prev = alt_s;
      d.div = q.div ^ src;
      d.tick = q.misc2[pcisp_pkg::MISC2_HALVE] ? (src && q.div) : src;

      // Top pin: request or ring indicate
      d.top_oe = 1'b1;
      d.top_o = q.misc2[pcisp_pkg::MISC2_RING] ? ring_s : top_req;

      // Second pin turns input in clock mode
      d.sec_oe = !q.misc2[pcisp_pkg::MISC2_ALTCLK];
      d.sec_o = second_req && !q.misc2[pcisp_pkg::MISC2_ALTCLK];

      // Middle pins: requests or the nibble bus
      if (q.misc2[pcisp_pkg::MISC2_GPMODE])
      begin
         d.mid_o = gp.nib_o;
         d.mid_oe = {4{gp.nib_oe}};
         d.stb_o = gp.stb_n;
         d.stb_oe = 1'b1;
      end
      else
      begin
         d.mid_o = mid_req;
         d.mid_oe = 4'hf;
         d.stb_o = 2'h3;
         d.stb_oe = 1'b0;
      end

      // Low pins: shared active low, or legacy active high
      if (q.misc2[pcisp_pkg::MISC2_PCIINT])
      begin
         d.low_o = 4'h0;
         d.low_oe = low_req;
      end
      else
      begin
         d.low_o = low_req;
         d.low_oe = 4'hf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset floats every driver
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '{misc2: pcisp_pkg::MISC2_RST, extdata: pcisp_pkg::EXTDATA_RST,
                frame_prev: 1'b1, stb_o: 2'h3, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign par_o = q.par_o;
   assign par_oe = q.par_oe;
   assign top_irq_or_ring_out_o = q.top_o;
   assign top_irq_or_ring_out_oe = q.top_oe;
   assign second_irq_or_alt_clock_o = q.sec_o;
   assign second_irq_or_alt_clock_oe = q.sec_oe;
   assign mid_irq_o = q.mid_o;
   assign mid_irq_oe = q.mid_oe;
   assign legacy_irq_or_pci_line_o = q.low_o;
   assign legacy_irq_or_pci_line_oe = q.low_oe;
   assign sense_or_strobe_one_o = q.stb_o[0];
   assign sense_or_strobe_two_o = q.stb_o[1];
   assign sense_or_strobe_one_oe = q.stb_oe;
   assign sense_or_strobe_two_oe = q.stb_oe;
   assign timer_tick = q.tick;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_addr_par_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (q.a_chk && par_s != q.exp_par) |=> q.aperr)
      else $error("Address parity error not flagged");

   a_data_par_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (q.d_chk && par_s != q.exp_par) |=> q.dperr)
      else $error("Data parity error not flagged");

   a_read_par_drive: assert property (@(posedge pclk) disable iff (!presetn)
      (tgt_read && tgt_trdy) |=> q.par_oe ##1 (q.par_oe == ($past(tgt_read) && $past(tgt_trdy))))
      else $error("Read parity drive window wrong");

   a_read_par_even: assert property (@(posedge pclk) disable iff (!presetn)
      q.par_oe |-> (^{q.par_o, $past(tgt_rdata), $past(cbe_s)}) == 1'b0)
      else $error("Driven parity not even");

   a_ring_route: assert property (@(posedge pclk) disable iff (!presetn)
      q.misc2[pcisp_pkg::MISC2_RING] |=> (q.top_o == $past(ring_s)))
      else $error("Ring indicate not routed");

   a_alt_clk_float: assert property (@(posedge pclk) disable iff (!presetn)
      q.misc2[pcisp_pkg::MISC2_ALTCLK] |=> !q.sec_oe)
      else $error("Clock input pin driven");

   a_low_shared_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (q.misc2[pcisp_pkg::MISC2_PCIINT] && low_req[0]) |=> (q.low_oe[0] && !q.low_o[0]))
      else $error("Shared line not pulled low");

   a_halve_tick: assert property (@(posedge pclk) disable iff (!presetn)
      (q.tick && q.misc2[pcisp_pkg::MISC2_HALVE] && $past(q.misc2[pcisp_pkg::MISC2_HALVE]))
      |=> !q.tick)
      else $error("Halved tick ran on consecutive cycles");

   a_strobe_float: assert property (@(posedge pclk) disable iff (!presetn)
      !q.misc2[pcisp_pkg::MISC2_GPMODE] |=> !q.stb_oe)
      else $error("Sense pin driven outside nibble mode");
endmodule

/* tb/pcisp_host_model.sv */
module pcisp_host_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Transfer request from the bench
   input wire logic go,
   input wire logic rd,
   input wire logic bad_a,
   input wire logic bad_d,
   input wire logic [31:0] data,
   // Bus pins
   output logic [31:0] ad,
   output logic [3:0] cbe_n,
   output logic frame_n,
   output logic irdy_n,
   output logic par
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // One address phase, then one write phase or a held read phase
   // Released lines toggle so that a late sample never sees a stale value
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ph <= 0;
         ad <= '0;
         cbe_n <= 4'hf;
         frame_n <= 1'b1;
         irdy_n <= 1'b1;
         par <= 1'b0;
      end
      else
      begin
         ad <= ~ad;
         cbe_n <= ~cbe_n;
         par <= ~par;
         frame_n <= 1'b1;
         irdy_n <= 1'b1;
         ph <= 0;
         if (ph == 0 && go)
         begin
            frame_n <= 1'b0;
            ad <= ~data;
            cbe_n <= rd ? 4'h6 : 4'h7;
            ph <= 1;
         end
         else if (ph == 1)
         begin
            irdy_n <= 1'b0;
            cbe_n <= 4'h0;
            ad <= rd ? ~ad : data;
            par <= ^{ad, cbe_n} ^ bad_a;
            ph <= 2;
         end
         else if (ph >= 2 && ph < 8 && rd)
         begin
            irdy_n <= 1'b0;
            cbe_n <= 4'h0;
            ph <= ph + 1;
         end
         else if (ph == 2)
            par <= ^{ad, cbe_n} ^ bad_d;
      end
endmodule

/* tb/pcisp_pins_tb.sv */
module pcisp_pins_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_EXT = 12'h028, A_CMD = 12'h02c, A_ST = 12'h030, A_M2 = 12'h078;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hpar;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, ad_i, tgt_rdata, rv;
   logic [3:0] cbe_n_i, mid_req, low_req, mid_irq_i, mid_irq_o, mid_irq_oe, nib_drv;
   logic [3:0] legacy_irq_or_pci_line_o, legacy_irq_or_pci_line_oe;
   logic frame_n_i, irdy_n_i, par_i, par_o, par_oe, tgt_read, tgt_trdy, top_req, second_req;
   logic ring_in, top_irq_or_ring_out_o, top_irq_or_ring_out_oe, second_irq_or_alt_clock_i;
   logic second_irq_or_alt_clock_o, second_irq_or_alt_clock_oe, sense_or_strobe_one_i;
   logic sense_or_strobe_one_o, sense_or_strobe_one_oe, sense_or_strobe_two_i;
   logic sense_or_strobe_two_o, sense_or_strobe_two_oe, timer_tick;
   logic go, hrd, bad_a, bad_d, trdy_rd, alt_pin, err;
   int n_mismatch = 0, checks = 0, cyc = 0, c1, c2;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Wire levels from every driver's enable
   assign par_i = par_oe ? par_o : hpar;
   assign mid_irq_i = (mid_irq_oe & mid_irq_o) | (~mid_irq_oe & nib_drv);
   assign second_irq_or_alt_clock_i = second_irq_or_alt_clock_oe ?
      second_irq_or_alt_clock_o : alt_pin;
   assign sense_or_strobe_one_i = sense_or_strobe_one_oe ? sense_or_strobe_one_o : 1'b1;
   assign sense_or_strobe_two_i = sense_or_strobe_two_oe ? sense_or_strobe_two_o : 1'b0;
   // Own target is ready on every write phase, and on reads when the bench says
   assign tgt_read = hrd;
   assign tgt_trdy = (~irdy_n_i & ~hrd) | trdy_rd;

   pcisp_host_model host (.pclk, .presetn, .go, .rd(hrd), .bad_a, .bad_d,
      .data(32'h5a5a_3c3c), .ad(ad_i), .cbe_n(cbe_n_i), .frame_n(frame_n_i),
      .irdy_n(irdy_n_i), .par(hpar));

   pcisp_pins dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ad_i, .cbe_n_i, .frame_n_i, .irdy_n_i, .par_i, .par_o, .par_oe,
      .tgt_read, .tgt_trdy, .tgt_rdata, .top_req, .second_req, .mid_req, .low_req, .ring_in,
      .top_irq_or_ring_out_o, .top_irq_or_ring_out_oe, .second_irq_or_alt_clock_i,
      .second_irq_or_alt_clock_o, .second_irq_or_alt_clock_oe, .mid_irq_i, .mid_irq_o,
      .mid_irq_oe, .legacy_irq_or_pci_line_o, .legacy_irq_or_pci_line_oe,
      .sense_or_strobe_one_i, .sense_or_strobe_one_o, .sense_or_strobe_one_oe,
      .sense_or_strobe_two_i, .sense_or_strobe_two_o, .sense_or_strobe_two_oe, .timer_tick);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the run needs a few hundred cycles
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Verdict
   task tally_and_finish;
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask

   // APB master: request held until pready is sampled high; only the hang guard ends a wait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv, err);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rv, err);
      chk(rv, e);
   endtask

   task automatic xfer(input logic r, input logic ba, input logic bd);
      @(posedge pclk);
      go <= 1'b1;
      hrd <= r;
      bad_a <= ba;
      bad_d <= bd;
      @(posedge pclk);
      go <= 1'b0;
   endtask

   // Counts ticks; in alt mode the second pin runs at one eighth of the bus clock
   task automatic ticks(input int n, input logic alt, output int c);
      c = 0;
      repeat (4) @(posedge pclk);
      for (int k = 0; k < n; k++)
      begin
         @(posedge pclk);
         if (timer_tick === 1'b1)
            c++;
         alt_pin <= alt && k < 64 && k[2];
      end
   endtask

   // Watches one nibble transfer; an input high nibble is offered once strobe one is done
   task automatic nib(input logic [7:0] v, input logic [3:0] oe, output int s1, output int s2);
      s1 = 0;
      s2 = 0;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge pclk);
         if (sense_or_strobe_one_o === 1'b0)
         begin
            s1++;
            chk({mid_irq_oe, mid_irq_o & oe}, {oe, v[3:0] & oe});
         end
         if (sense_or_strobe_two_o === 1'b0)
         begin
            s2++;
            chk({mid_irq_oe, mid_irq_o & oe}, {oe, v[7:4] & oe});
         end
         if (s1 == 4)
            nib_drv <= v[7:4];
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, go, hrd, bad_a, bad_d, trdy_rd, alt_pin} = '0;
      {top_req, second_req, mid_req, low_req, ring_in, nib_drv, tgt_rdata} = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({top_irq_or_ring_out_oe, second_irq_or_alt_clock_oe, mid_irq_oe}, 6'h3f);
      rdc(A_M2, 32'h0);
      rdc(A_EXT, 32'h0);
      apb(1'b1, 12'h3fc, 32'h0, rv, err);
      chk(err, 1'b1);
      rdc(A_ST, 32'h08);
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b0, i[0], i[1]);
         repeat (10) @(posedge pclk);
         apb(1'b0, A_ST, 32'h0, rv, err);
         chk(rv[1:0], i[1:0]);
         wr(A_ST, 32'h3);
      end
      rdc(A_ST, 32'h08);
      xfer(1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge pclk);
      trdy_rd <= 1'b1;
      tgt_rdata <= 32'h0000_0007;
      repeat (2) @(posedge pclk);
      chk({par_oe, par_o}, 2'b11);
      trdy_rd <= 1'b0;
      @(posedge pclk);
      chk(par_oe, 1'b1);
      @(posedge pclk);
      chk(par_oe, 1'b0);
      repeat (8) @(posedge pclk);
      hrd <= 1'b0;
      ticks(40, 1'b0, c1);
      chk(c1, 40);
      wr(A_M2, 32'h10);
      ticks(40, 1'b0, c1);
      chk(c1, 20);
      wr(A_M2, 32'h01);
      // The control bit lands at the commit edge, the pin enable one edge later
      repeat (2) @(posedge pclk);
      chk(second_irq_or_alt_clock_oe, 1'b0);
      ticks(72, 1'b1, c1);
      chk(c1, 8);
      wr(A_M2, 32'h11);
      ticks(72, 1'b1, c1);
      chk(c1, 4);
      wr(A_M2, 32'h0);
      top_req <= 1'b1;
      second_req <= 1'b1;
      mid_req <= 4'h5;
      low_req <= 4'ha;
      repeat (4) @(posedge pclk);
      chk({top_irq_or_ring_out_o, second_irq_or_alt_clock_o, mid_irq_o,
           legacy_irq_or_pci_line_o, legacy_irq_or_pci_line_oe}, 14'h35af);
      wr(A_M2, 32'h84);
      repeat (5) @(posedge pclk);
      chk({top_irq_or_ring_out_o, legacy_irq_or_pci_line_oe}, 5'h0a);
      ring_in <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(top_irq_or_ring_out_o, 1'b1);
      wr(A_M2, 32'h02);
      wr(A_EXT, 32'ha5);
      fork
         nib(8'ha5, 4'hf, c1, c2);
         wr(A_EXT, 32'hff);
      join
      chk({c1[3:0], c2[3:0]}, 8'h44);
      rdc(A_EXT, 32'ha5);
      nib_drv <= 4'h3;
      wr(A_CMD, 32'h1);
      nib(8'hc3, 4'h0, c1, c2);
      chk({c1[3:0], c2[3:0]}, 8'h44);
      rdc(A_EXT, 32'hc3);
      wr(A_M2, 32'h81);
      presetn <= 1'b0;
      @(posedge pclk);
      chk({top_irq_or_ring_out_oe, second_irq_or_alt_clock_oe, mid_irq_oe,
           legacy_irq_or_pci_line_oe, par_oe}, 11'h0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_M2, 32'h0);
      tally_and_finish;
   end
endmodule
